// file: core/fbw_burst_writer.sv
/*
  Software flash burst writer: APB register file, burst sequencer and
  interrupt logic in front of a serial flash.
  Assumes one 20 MHz sys_clk, a synchronous active low reset and an APB
  master on the same clock; the flash sits on the pins of flashPins.
*/
`timescale 1ns/10ps

module fbw_burst_writer
  import fbw_pkg::*;
#(
  parameter int HALF_DIV = SCLK_HALF_DIV,
  parameter logic [31:0] OPCODE_INIT = OPCODE_RESET
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // apb slave
  input wire fbw_apb_req_s apbReq,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // flash pins
  output fbw_flash_pins_s flashPins,
  input wire logic flashMiso,
  // interrupt
  output logic irq
);

  // ==========================================================
  // declarations
  fbw_state_e state, next_state;
  logic [ADDR_W-1:0] addrReg, next_addrReg;
  logic [1:0] cmdReg, next_cmdReg;
  logic command_valid, next_command_valid;
  logic updDone, next_updDone;
  logic wordDone, next_wordDone;
  logic globalDone, next_globalDone;
  logic [31:0] dataReg, next_dataReg;
  logic [CNT_W-1:0] countReg, next_countReg;
  logic abortReq, next_abortReq;
  logic [31:0] opcodeReg, next_opcodeReg;
  logic issued, next_issued;
  logic [1:0] byteIdx, next_byteIdx;
  logic [8:0] bytesLeft, next_bytesLeft;
  logic csB, next_csB;
  logic [IRQ_W-1:0] irqStatus, next_irqStatus;
  logic [IRQ_W-1:0] irqEnable, next_irqEnable;
  logic [IRQ_W-1:0] events;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic wrAny, rdSetup, wrCtrl, wrData, wrCnt, wrOp, wrClr, wrEn;
  logic idle, sending, abortable, busyBit;
  logic shStart, shBusy, shDone, shSclk, shMosi;
  logic [7:0] shTx, shRx;
  logic [8:0] burstBytes;
  logic [31:0] ctrlView;

  // ==========================================================
  // apb decode: zero wait states, write acts in the access phase
  assign pready = apbReq.psel && apbReq.penable;
  assign wrAny = pready && apbReq.pwrite;
  assign rdSetup = apbReq.psel && !apbReq.penable;
  assign wrCtrl = wrAny && (apbReq.paddr == OFS_CONTROL);
  assign wrData = wrAny && (apbReq.paddr == OFS_DATA);
  assign wrCnt = wrAny && (apbReq.paddr == OFS_COUNTER);
  assign wrOp = wrAny && (apbReq.paddr == OFS_OPCODE);
  assign wrClr = wrAny && (apbReq.paddr == OFS_IRQ_CLEAR);
  assign wrEn = wrAny && (apbReq.paddr == OFS_IRQ_ENABLE);

  // ==========================================================
  // state classes
  assign idle = (state == ST_IDLE);
  assign busyBit = !idle;
  assign sending = (state == ST_WREN) || (state == ST_HDR) ||
                   (state == ST_DATA) || (state == ST_POLL);
  // once the last word is out the write is committed, so abort waits
  assign abortable = (state == ST_WREN) || (state == ST_HDR) ||
                     (state == ST_WAITW) || (state == ST_DATA);
  assign shStart = sending && !issued && !shBusy &&
                   !(abortReq && abortable);
  // length clamp: one command never programs more than one page
  assign burstBytes = (countReg > CNT_W'(MAX_BURST_BYTES)) ?
                      MAX_BURST_BYTES : countReg[8:0];

  // ==========================================================
  // byte to send, opcodes taken from the opcode register
  always_comb begin
    shTx = 8'h00;
    case (state)
      ST_WREN: shTx = opcodeReg[OP_WREN_LSB +: 8];
      ST_HDR: begin
        case (byteIdx)
          2'h0: shTx = opcodeReg[OP_PROG_LSB +: 8];
          2'h1: shTx = addrReg[23:16];
          2'h2: shTx = addrReg[15:8];
          default: shTx = addrReg[7:0];
        endcase
      end
      ST_DATA: begin
        case (byteIdx)
          2'h0: shTx = dataReg[7:0];
          2'h1: shTx = dataReg[15:8];
          2'h2: shTx = dataReg[23:16];
          default: shTx = dataReg[31:24];
        endcase
      end
      ST_POLL: shTx = (byteIdx == 2'h0) ? opcodeReg[OP_RDSR_LSB +: 8] :
                      8'h00;
      default: shTx = 8'h00;
    endcase
  end

  fbw_byte_shifter #(
    .HALF_DIV(HALF_DIV)
  ) u_shifter (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start(shStart),
    .txByte(shTx),
    .busy(shBusy),
    .done(shDone),
    .rxByte(shRx),
    .sclk(shSclk),
    .mosi(shMosi),
    .miso(flashMiso)
  );

  assign flashPins = '{sclk: shSclk, csB: csB, mosi: shMosi};

  // ==========================================================
  // register writes and burst sequencer
  always_comb begin
    next_state = state;
    next_addrReg = addrReg;
    next_cmdReg = cmdReg;
    next_command_valid = command_valid;
    next_updDone = updDone;
    next_wordDone = wordDone;
    next_globalDone = globalDone;
    next_dataReg = dataReg;
    next_countReg = countReg;
    next_abortReq = abortReq;
    next_opcodeReg = opcodeReg;
    next_issued = issued;
    next_byteIdx = byteIdx;
    next_bytesLeft = bytesLeft;
    next_csB = csB;
    events = '0;
    // software side; address, command and count are locked while a command runs
    if (wrCtrl) begin
      if (!apbReq.pwdata[UPD_BIT]) begin
        next_updDone = 1'b0;
      end
      if (idle) begin
        next_addrReg = apbReq.pwdata[ADDR_W-1:0];
        next_cmdReg = apbReq.pwdata[CMD_LSB +: 2];
        if (apbReq.pwdata[COMMAND_VALID_BIT] &&
            apbReq.pwdata[CMD_LSB +: 2] == CMD_DMA_WRITE &&
            burstBytes != 9'h000) begin
          next_command_valid = 1'b1;
          next_wordDone = 1'b0;
          next_globalDone = 1'b0;
          next_bytesLeft = burstBytes;
          next_byteIdx = 2'h0;
          next_state = ST_WREN;
        end
      end
    end
    if (wrData) begin
      next_dataReg = apbReq.pwdata;
      if (state == ST_WAITW) begin
        next_wordDone = 1'b0;
        next_byteIdx = 2'h0;
        next_state = ST_DATA;
      end
    end
    if (wrCnt) begin
      if (idle) begin
        next_countReg = apbReq.pwdata[CNT_W-1:0];
      end else if (apbReq.pwdata[ABORT_BIT]) begin
        next_abortReq = 1'b1;
      end
    end
    if (wrOp) begin
      next_opcodeReg = apbReq.pwdata;
    end
    // flash side: a finished byte moves the sequence on
    if (shDone) begin
      next_issued = 1'b0;
      case (state)
        ST_WREN: begin
          next_csB = 1'b1; // write enable stands alone under select
          next_state = ST_HDR;
          next_byteIdx = 2'h0;
        end
        ST_HDR: begin
          next_byteIdx = byteIdx + 2'h1;
          if (byteIdx == 2'h3) begin
            next_wordDone = 1'b1;
            events[IRQ_WORD] = 1'b1;
            next_state = ST_WAITW;
          end
        end
        ST_DATA: begin
          next_bytesLeft = bytesLeft - 9'h001;
          next_byteIdx = byteIdx + 2'h1;
          if (bytesLeft == 9'h001) begin
            next_wordDone = 1'b1;
            events[IRQ_WORD] = 1'b1;
            next_csB = 1'b1;
            next_byteIdx = 2'h0;
            next_state = ST_POLL;
          end else if (byteIdx == 2'h3) begin
            next_wordDone = 1'b1;
            events[IRQ_WORD] = 1'b1;
            next_state = ST_WAITW;
          end
        end
        ST_POLL: begin
          if (byteIdx == 2'h0) begin
            next_byteIdx = 2'h1;
          end else begin
            next_csB = 1'b1;
            next_byteIdx = 2'h0;
            if (!shRx[FLASH_WIP_BIT]) begin
              next_state = ST_IDLE;
              next_command_valid = 1'b0;
              next_globalDone = 1'b1;
              next_updDone = 1'b1;
              next_abortReq = 1'b0;
              events[IRQ_GLOBAL] = 1'b1;
            end
          end
        end
        default: next_issued = 1'b0;
      endcase
    end
    if (shStart) begin
      next_issued = 1'b1;
      next_csB = 1'b0;
    end
    // abort only between bytes, so a byte is never cut short
    if (abortReq && abortable && !issued) begin
      next_state = ST_IDLE;
      next_command_valid = 1'b0;
      next_globalDone = 1'b1;
      next_wordDone = 1'b1;
      next_abortReq = 1'b0;
      next_csB = 1'b1;
      events[IRQ_GLOBAL] = 1'b1;
      events[IRQ_ABORT] = 1'b1;
    end
  end

  // ==========================================================
  // sequencer registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      addrReg <= '0;
      cmdReg <= CMD_RESET;
      command_valid <= 1'b0;
      updDone <= 1'b0;
      wordDone <= 1'b1;
      globalDone <= 1'b1;
      dataReg <= 32'h0000_0000;
      countReg <= '0;
      abortReq <= 1'b0;
      opcodeReg <= OPCODE_INIT;
      issued <= 1'b0;
      byteIdx <= 2'h0;
      bytesLeft <= 9'h000;
      csB <= 1'b1;
    end else begin
      state <= next_state;
      addrReg <= next_addrReg;
      cmdReg <= next_cmdReg;
      command_valid <= next_command_valid;
      updDone <= next_updDone;
      wordDone <= next_wordDone;
      globalDone <= next_globalDone;
      dataReg <= next_dataReg;
      countReg <= next_countReg;
      abortReq <= next_abortReq;
      opcodeReg <= next_opcodeReg;
      issued <= next_issued;
      byteIdx <= next_byteIdx;
      bytesLeft <= next_bytesLeft;
      csB <= next_csB;
    end
  end

  // ==========================================================
  // interrupts: a new event beats a clear in the same cycle
  always_comb begin
    next_irqStatus = irqStatus;
    next_irqEnable = irqEnable;
    if (wrClr) begin
      next_irqStatus = irqStatus & ~apbReq.pwdata[IRQ_W-1:0];
    end
    next_irqStatus = next_irqStatus | events;
    if (wrEn) begin
      next_irqEnable = apbReq.pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irqStatus <= '0;
      irqEnable <= '0;
    end else begin
      irqStatus <= next_irqStatus;
      irqEnable <= next_irqEnable;
    end
  end

  assign irq = |(irqStatus & irqEnable);

  // ==========================================================
  // read data captured in the setup cycle, held through access
  assign ctrlView = {globalDone, wordDone, updDone, 1'b0, busyBit, command_valid,
                     cmdReg, addrReg};

  always_comb begin
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (rdSetup) begin
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      case (apbReq.paddr)
        OFS_CONTROL: next_prdata = ctrlView;
        OFS_DATA: next_prdata = dataReg;
        OFS_COUNTER: next_prdata = {abortReq, 6'h00, countReg};
        OFS_OPCODE: next_prdata = opcodeReg;
        OFS_IRQ_STATUS: next_prdata = {29'h0000_0000, irqStatus};
        OFS_IRQ_CLEAR: next_prdata = 32'h0000_0000;
        OFS_IRQ_ENABLE: next_prdata = {29'h0000_0000, irqEnable};
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule : fbw_burst_writer

// file: shared/fbw_pkg.sv
/*
  Shared constants, types and register map of the software flash burst
  writer. Assumes an APB slave port with 16-bit byte addresses and a
  serial flash that takes opcode, three address bytes and data bytes.
*/
package fbw_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [15:0] OFS_CONTROL = 16'h1030;
  localparam logic [15:0] OFS_DATA = 16'h1034;
  localparam logic [15:0] OFS_COUNTER = 16'h1038;
  localparam logic [15:0] OFS_OPCODE = 16'h103C;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'h1040;
  localparam logic [15:0] OFS_IRQ_CLEAR = 16'h1044;
  localparam logic [15:0] OFS_IRQ_ENABLE = 16'h1048;

  // ==========================================================
  // control register fields
  localparam int ADDR_W = 24;
  localparam int CMD_LSB = 24;
  localparam int COMMAND_VALID_BIT = 26;
  localparam int BUSY_BIT = 27;
  localparam int UPD_BIT = 29;
  localparam int WDONE_BIT = 30;
  localparam int GDONE_BIT = 31;
  localparam logic [1:0] CMD_DMA_WRITE = 2'h1;
  localparam logic [1:0] CMD_RESET = 2'h0;

  // ==========================================================
  // counter register fields
  localparam int CNT_W = 25;
  localparam int ABORT_BIT = 31;
  localparam logic [8:0] MAX_BURST_BYTES = 9'h100;

  // ==========================================================
  // opcode register fields, flash status
  localparam int OP_PROG_LSB = 0;
  localparam int OP_WREN_LSB = 8;
  localparam int OP_RDSR_LSB = 16;
  localparam logic [31:0] OPCODE_RESET = 32'h0005_0602;
  localparam int FLASH_WIP_BIT = 0;

  // ==========================================================
  // interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_WORD = 0;
  localparam int IRQ_GLOBAL = 1;
  localparam int IRQ_ABORT = 2;

  // ==========================================================
  // timing: sys_clk cycles per flash clock half period
  localparam int SCLK_HALF_DIV = 4;

  // ==========================================================
  // types
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WREN = 6'h02,
    ST_HDR = 6'h04,
    ST_WAITW = 6'h08,
    ST_DATA = 6'h10,
    ST_POLL = 6'h20
  } fbw_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } fbw_apb_req_s;

  typedef struct packed {
    logic sclk;
    logic csB;
    logic mosi;
  } fbw_flash_pins_s;

endpackage : fbw_pkg

// file: core/fbw_byte_shifter.sv
/*
  Serial byte shifter: sends one byte msb first and captures one byte
  back, clock idle low, data out on falling edge, sampled on rising.
  Assumes sys_clk only; the flash data input is an asynchronous pin.
*/
`timescale 1ns/10ps
module fbw_byte_shifter
  import fbw_pkg::*;
#(
  parameter int HALF_DIV = SCLK_HALF_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // byte request
  input wire logic start,
  input wire logic [7:0] txByte,
  output logic busy,
  output logic done,
  output logic [7:0] rxByte,
  // flash pins
  output logic sclk,
  output logic mosi,
  input wire logic miso
);

  // ==========================================================
  // state
  logic [15:0] divCnt, next_divCnt;
  logic [2:0] bitCnt, next_bitCnt;
  logic [7:0] shiftReg, next_shiftReg;
  logic active, next_active, next_sclk, next_mosi, next_done;
  logic misoMeta, misoSync;
  logic tick;

  // elaboration check: shorter half periods let the edges collide
  if (HALF_DIV < 3 || HALF_DIV > 65535) begin : g_div_check
    $error("HALF_DIV out of range");
  end

  assign tick = active && (divCnt == 16'(HALF_DIV - 1));
  assign busy = active;
  assign rxByte = shiftReg;

  // ==========================================================
  // next state: a byte is eight rising and eight falling edges
  always_comb begin
    next_divCnt = tick ? 16'h0000 : divCnt + 16'h0001;
    next_bitCnt = bitCnt;
    next_shiftReg = shiftReg;
    next_active = active;
    next_sclk = sclk;
    next_mosi = mosi;
    next_done = 1'b0;
    if (!active) begin
      next_divCnt = 16'h0000;
      if (start) begin
        next_active = 1'b1;
        next_shiftReg = txByte;
        next_mosi = txByte[7];
        next_bitCnt = 3'h0;
      end
    end else if (tick) begin
      next_sclk = !sclk;
      if (!sclk) begin
        next_shiftReg = {shiftReg[6:0], misoSync}; // sample on rise
        next_bitCnt = bitCnt + 3'h1;
      end else if (bitCnt == 3'h0) begin
        next_active = 1'b0;   // eighth falling edge ends the byte
        next_done = 1'b1;
      end else begin
        next_mosi = shiftReg[7];
      end
    end
  end

  // ==========================================================
  // registers; miso passes two flip-flops before use
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      divCnt <= 16'h0000;
      bitCnt <= 3'h0;
      shiftReg <= 8'h00;
      active <= 1'b0;
      sclk <= 1'b0;
      mosi <= 1'b0;
      done <= 1'b0;
      misoMeta <= 1'b0;
      misoSync <= 1'b0;
    end else begin
      divCnt <= next_divCnt;
      bitCnt <= next_bitCnt;
      shiftReg <= next_shiftReg;
      active <= next_active;
      sclk <= next_sclk;
      mosi <= next_mosi;
      done <= next_done;
      misoMeta <= miso;
      misoSync <= misoMeta;
    end
  end

endmodule : fbw_byte_shifter

// file: testbench/fbw_burst_writer_chk.sv
/*
  Port checker for the flash burst writer, attached by bind.
  Assumes one sys_clk domain and the synchronous active low rst_b.
*/
`timescale 1ns/10ps
module fbw_burst_writer_chk
  import fbw_pkg::*;
#(
  parameter int HALF_DIV = SCLK_HALF_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // apb side
  input wire fbw_apb_req_s apbReq,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // flash side and interrupt
  input wire fbw_flash_pins_s flashPins,
  input wire logic flashMiso,
  input wire logic irq
);
  logic [7:0] quietCnt, next_quietCnt, hiCnt, next_hiCnt;
  logic mapped, ctlWr;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ======================================
  // helpers: address decode, idle span, clock high span
  assign mapped = apbReq.paddr inside {OFS_CONTROL, OFS_DATA, OFS_COUNTER,
    OFS_OPCODE, OFS_IRQ_STATUS, OFS_IRQ_CLEAR, OFS_IRQ_ENABLE};
  assign ctlWr = apbReq.psel && apbReq.penable && apbReq.pwrite &&
    apbReq.paddr == OFS_CONTROL;
  // saturating, so a long quiet select means the sequencer is idle
  always_comb begin
    next_quietCnt = quietCnt == 8'hFF ? quietCnt : quietCnt + 8'h01;
    if (!flashPins.csB) begin
      next_quietCnt = 8'h00;
    end
    next_hiCnt = flashPins.sclk ? hiCnt + 8'h01 : 8'h00;
  end
  // reset counts as idle: nothing runs after reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      quietCnt <= 8'hFF;
      hiCnt <= 8'h00;
    end else begin
      quietCnt <= next_quietCnt;
      hiCnt <= next_hiCnt;
    end
  end

  // ======================================
  // assertions
  zero_wait_a: assert property (
    pready == (apbReq.psel && apbReq.penable))
    else $error("pready does not follow the access phase");
  unmapped_err_a: assert property (
    apbReq.psel && !apbReq.penable && !mapped
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  mapped_ok_a: assert property (
    apbReq.psel && !apbReq.penable && mapped
    |=> !pslverr) else $error("mapped access refused");
  sclk_frame_a: assert property (flashPins.sclk |-> !flashPins.csB)
    else $error("flash clock outside a frame");
  sclk_width_a: assert property ($fell(flashPins.sclk)
    |-> hiCnt == 8'(HALF_DIV)) else $error("flash clock high time wrong");
  mosi_stable_a: assert property (
    flashPins.sclk && $past(flashPins.sclk)
    |-> $stable(flashPins.mosi)) else $error("data moved while clock high");
  reserved_cmd_a: assert property (ctlWr && apbReq.pwdata[COMMAND_VALID_BIT] &&
    apbReq.pwdata[25:24] != CMD_DMA_WRITE && quietCnt == 8'hFF
    |=> flashPins.csB [*8]) else $error("reserved command started");
  invalid_cmd_a: assert property (ctlWr && !apbReq.pwdata[COMMAND_VALID_BIT] &&
    quietCnt == 8'hFF |=> flashPins.csB [*8])
    else $error("command started without valid");
  irq_clear_a: assert property (apbReq.psel && apbReq.penable &&
    apbReq.pwrite && apbReq.paddr == OFS_IRQ_CLEAR &&
    apbReq.pwdata[2:0] == 3'h7 && quietCnt == 8'hFF |=> !irq)
    else $error("interrupt stays after clear");

  frame_c: cover property ($fell(flashPins.csB));
  irq_c: cover property ($rose(irq));
  err_c: cover property (pslverr);
  // a busy reply seen on the data input while a frame runs
  busy_poll_c: cover property (!flashPins.csB && $rose(flashPins.sclk) &&
    flashMiso);
endmodule : fbw_burst_writer_chk

bind fbw_burst_writer fbw_burst_writer_chk #(.HALF_DIV(HALF_DIV)) chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .apbReq(apbReq), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .flashPins(flashPins),
  .flashMiso(flashMiso), .irq(irq));

// file: testbench/fbw_flash_model.sv
/*
  Behavioural serial flash: logs the first 64 bytes received and answers status
  polls busy BUSY_POLLS times, then ready.
  Assumes clock idle low, msb first, sampled on the rising flash clock.
*/
`timescale 1ns/10ps
module fbw_flash_model
  import fbw_pkg::*;
#(
  parameter int BUSY_POLLS = 2,
  parameter logic [7:0] READ_STATUS = 8'h05
) (
  // reference clock for the released line
  input wire logic sys_clk,
  // flash pins
  input wire fbw_flash_pins_s pins,
  output logic miso
);
  logic [7:0] shReg = 8'h00;
  logic [7:0] byteLog [64];
  logic pollFrame = 1'b0;
  logic reply = 1'b0;
  int bitCnt = 0;
  int byteCnt = 0;
  int frameByte = 0;
  int polls = 0;

  // ======================================
  // byte capture on the rising flash clock
  always @(posedge pins.sclk) begin
    if (!pins.csB) begin
      shReg = {shReg[6:0], pins.mosi};
      bitCnt++;
      if (bitCnt == 8) begin
        if (byteCnt < 64) byteLog[byteCnt] = shReg;
        if (frameByte == 0 && shReg == READ_STATUS) begin
          pollFrame = 1'b1;
          reply = polls < BUSY_POLLS;
          polls++;
        end
        byteCnt++;
        frameByte++;
        bitCnt = 0;
      end
    end
  end
  // deselect ends the frame
  always @(posedge pins.csB) begin
    bitCnt = 0;
    frameByte = 0;
    pollFrame = 1'b0;
  end
  // released line toggles so a stale value is never mistaken for data
  initial miso = 1'b0;
  always @(posedge sys_clk) begin
    miso <= (!pins.csB && pollFrame && frameByte == 1) ? reply : ~miso;
  end
endmodule : fbw_flash_model

// file: testbench/testbench.sv
/*
  Self-checking bench: APB master tasks drive register sequences.
  Assumes the flash model on the pins and the checker bound to dut.
*/
`timescale 1ns/10ps
module testbench;
  import fbw_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  fbw_apb_req_s apbReq = '0;
  logic pready, pslverr, errSeen, irq, flashMiso;
  logic [31:0] prdata, rdata;
  fbw_flash_pins_s flashPins;
  int bad_count = 0;
  int compares = 0;
  logic [7:0] expLog [12] = '{8'h06, 8'h02, 8'h12, 8'h34, 8'h56, 8'h11,
    8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h05};

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  fbw_burst_writer #(.HALF_DIV(3)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .apbReq(apbReq), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .flashPins(flashPins), .flashMiso(flashMiso), .irq(irq));
  fbw_flash_model #(.BUSY_POLLS(2)) flash (.sys_clk(sys_clk),
    .pins(flashPins), .miso(flashMiso));

  // ======================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer; request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [15:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    apbReq <= '{1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdata = prdata;
    errSeen = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] m,
    input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rdata & m, e);
  endtask : rd
  // bounded poll of one control bit
  task automatic wait_ctl(input int b);
    int n;
    n = 0;
    do begin
      xfer(1'b0, OFS_CONTROL, 32'h0);
      n++;
    end while (rdata[b] !== 1'b1 && n < 3000);
    if (n >= 3000) bad_count++;
  endtask : wait_ctl
  task automatic finish_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // ======================================
  // watchdog: far beyond the 1300 or so cycles the tests need
  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(OFS_CONTROL, '1, 32'hC000_0000);
    rd(OFS_DATA, '1, 32'h0);
    rd(OFS_COUNTER, '1, 32'h0);
    rd(OFS_OPCODE, '1, 32'h0005_0602);
    rd(16'h1050, '1, 32'h0);
    check({31'h0, errSeen}, 32'h1);
    // a valid write command with length zero starts nothing
    wr(OFS_CONTROL, 32'h0500_0000);
    rd(OFS_CONTROL, 32'hFC00_0000, 32'hC000_0000);
    wr(OFS_COUNTER, 32'h0000_0006);
    // reserved codes and a code without valid start nothing
    for (int c = 0; c < 4; c++) begin
      if (c != 1) begin
        wr(OFS_CONTROL, {5'h0, 1'b1, 2'(c), 24'h0});
        rd(OFS_CONTROL, 32'hFC00_0000, 32'hC000_0000);
      end
    end
    wr(OFS_CONTROL, 32'h0112_3456);
    rd(OFS_CONTROL, 32'hFC00_0000, 32'hC000_0000);
    rd(OFS_COUNTER, '1, 32'h6);
    // six byte burst: one full word then two bytes
    wr(OFS_IRQ_ENABLE, 32'h3);
    wr(OFS_CONTROL, 32'h0512_3456);
    rd(OFS_CONTROL, '1, 32'h0D12_3456);
    wait_ctl(WDONE_BIT);
    wr(OFS_DATA, 32'h4433_2211);
    rd(OFS_CONTROL, 32'h4000_0000, 32'h0);
    rd(OFS_DATA, '1, 32'h4433_2211);
    wait_ctl(WDONE_BIT);
    wr(OFS_DATA, 32'h8877_6655);
    wait_ctl(GDONE_BIT);
    rd(OFS_CONTROL, 32'hFC00_0000, 32'hE000_0000);
    for (int i = 0; i < 12; i++) begin
      check({24'h0, flash.byteLog[i]}, {24'h0, expLog[i]});
    end
    check(32'(flash.byteCnt), 32'd17);
    @(negedge sys_clk);
    check({31'h0, irq}, 32'h1);
    rd(OFS_IRQ_STATUS, '1, 32'h3);
    wr(OFS_IRQ_ENABLE, 32'h0);
    @(negedge sys_clk);
    check({31'h0, irq}, 32'h0);
    // let the idle span run out before the clear
    repeat (260) @(posedge sys_clk);
    wr(OFS_IRQ_ENABLE, 32'h3);
    wr(OFS_IRQ_CLEAR, 32'h7);
    rd(OFS_IRQ_STATUS, '1, 32'h0);
    wr(OFS_CONTROL, 32'h0);
    rd(OFS_CONTROL, 32'hFC00_0000, 32'hC000_0000);
    // abort: ignored while idle, taken mid command
    wr(OFS_COUNTER, 32'h8000_0008);
    rd(OFS_COUNTER, '1, 32'h8);
    wr(OFS_CONTROL, 32'h0500_0100);
    wr(OFS_COUNTER, 32'h8000_0000);
    rd(OFS_COUNTER, '1, 32'h8000_0008);
    wait_ctl(GDONE_BIT);
    rd(OFS_CONTROL, 32'hFC00_0000, 32'hC000_0000);
    rd(OFS_COUNTER, '1, 32'h8);
    rd(OFS_IRQ_STATUS, '1, 32'h6);
    @(negedge sys_clk);
    check({31'h0, flashPins.csB}, 32'h1);
    finish_test();
  end
endmodule : testbench
